// ===== common/cpp_defines.svh
// Constants of the configuration packet processor
`ifndef CPP_DEFINES_SVH
`define CPP_DEFINES_SVH
`define CPP_SYNC_WORD 32'h5a3c_c3a5
`define CPP_TYPE1 3'h1
`define CPP_TYPE2 3'h2
`define CPP_OP_WRITE 2'h2
`define CPP_OP_READ 2'h1
`define CPP_ADDR_CRC 14'h0000
`define CPP_ADDR_FAR 14'h0001
`define CPP_ADDR_FRAME_DATA_INPUT_REGISTER 14'h0002
`define CPP_ADDR_CMD 14'h0003
`define CPP_ADDR_CTL 14'h0004
`define CPP_ADDR_MASK 14'h0005
`define CPP_ADDR_COR 14'h0006
`define CPP_ADDR_FLR 14'h0007
`define CPP_ADDR_ID 14'h0008
`define CPP_CMD_WRITE_CONFIG_CMD 4'h1
`define CPP_CMD_START 4'h2
`define CPP_CMD_CHECKSUM_RESET_CMD 4'h3
`define CPP_CMD_SWITCH 4'h4
`define CPP_CMD_DESYNC 4'h5
`define CPP_CRC_ADDR_W 5
`define CPP_COR_CLKSEL_LSB 0
`define CPP_COR_CLKSEL_W 6
`define CPP_STAT_CRC_ERR 0
`define CPP_STAT_ALIGNED 1
`define CPP_STAT_ACTIVE 2
`define CPP_STAT_DONE 12
`define CPP_STAT_ID_ERR 13
`define CPP_DONE_DLY 3'h3
`define CPP_FINISH_CYC 4'h8
`define CPP_DEVICE_CODE 32'h0123_4567
`endif

// ===== common/cpp_pkg.sv
// Types of the configuration packet processor
package cpp_pkg;
    typedef enum logic [1:0] {
        PK_HDR = 2'b00,
        PK_T1 = 2'b01,
        PK_T2 = 2'b10
    } cpp_pk_e;
    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [31:0] data;
    } cpp_frame_wr_s;
    typedef struct packed {
        logic sw;
        logic [5:0] sel;
    } cpp_clk_sw_s;
endpackage

// ===== hdl/cpp_core.sv
// Configuration packet processor: word alignment, packets, commands and CRC
// What this block does
// R1 - Ignore stream until synchronization word seen
// R2 - Bit after sync starts a new word
// R3 - Decode Type 1 header fields
// R4 - Type 1 carries 0 to 2047 words
// R5 - Decode Type 2 header, 27-bit count
// R6 - Type 2 only after Type 1
// R7 - Type 2 data goes to Type 1 register
// R8 - Frames via Type 1 alone or pair
// R9 - Checksum reset command clears CRC
// R10 - Clock switch applies options register clock field
// R11 - Frame loading only after write-config command
// R12 - Identity register checked against device code
// R13 - Loader starts frame address at zero
// R14 - No user operation before final CRC
// R15 - Finish 8 to 16 cycles after release
// R16 - Release command drops word alignment
// R17 - Done within seven cycles of CRC load
// R18 - Loader clocks trailing dummy data
// R19 - Serial 16-bit CRC shift register taps
// R20 - Nonzero CRC after load means failure
// R21 - CRC takes address then data LSB first
// R22 - First data pin carries byte MSB
// R23 - Frame address advances after each frame
// R24 - Identity mismatch flag on unvalidated frame write
// R25 - Unknown header type is a no-op
`include "cpp_defines.svh"
module cpp_core (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_byte_mode,
    input wire logic i_config_clock,
    input wire logic i_cfg_valid,
    input wire logic [7:0] i_cfg_data,
    output cpp_pkg::cpp_frame_wr_s o_frame_wr,
    output cpp_pkg::cpp_clk_sw_s o_clk_sw,
    output logic o_done,
    output logic o_user_active,
    output logic [31:0] o_status
);
    import cpp_pkg::*;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [31:0] d,
                                             input logic [`CPP_CRC_ADDR_W-1:0] a);
        logic [15:0] r;
        logic [`CPP_CRC_ADDR_W+31:0] s;
        logic x;
        r = c;
        s = {d, a};
        for (int i = 0; i < `CPP_CRC_ADDR_W + 32; i++) begin
            x = s[i] ^ r[15];
            r = {r[14] ^ x, r[13:2], r[1] ^ x, r[0], x}; // R19
        end
        return r;
    endfunction

    // Link-side reset release and synchronised control levels
    logic [1:0] lrst_q;
    logic [1:0] lmode_q;
    logic [1:0] len_q;
    always_ff @(posedge i_config_clock or posedge i_rst) begin
        if (i_rst) begin
            lrst_q <= 2'h3;
            lmode_q <= 2'h0;
            len_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b0};
            lmode_q <= {lmode_q[0], i_byte_mode};
            len_q <= {len_q[0], i_clk_en};
        end
    end
    wire lrst = lrst_q[1];
    wire byte_mode = lmode_q[1];
    wire lce = len_q[1] && i_cfg_valid;

    // Word assembly
    logic [7:0] byte_in;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign byte_in[7-g] = i_cfg_data[g]; // R22
        end
    endgenerate
    logic [31:0] sh_q;
    logic [4:0] cnt_q;
    logic aligned_q;
    wire [31:0] sh_d = byte_mode ? {sh_q[23:0], byte_in} : {sh_q[30:0], i_cfg_data[0]};
    wire [5:0] cnt_sum = {1'b0, cnt_q} + (byte_mode ? 6'h08 : 6'h01);
    wire sync_hit = !aligned_q && (sh_d == `CPP_SYNC_WORD); // R1
    wire word_rdy = aligned_q && cnt_sum[5];
    wire [31:0] w = sh_d;

    // Header decode
    wire [2:0] h_type = w[31:29];
    wire [1:0] h_op = w[28:27];
    wire [13:0] h_addr = w[26:13];
    wire [10:0] h_cnt1 = w[10:0];
    wire [26:0] h_cnt2 = w[26:0];

    cpp_pk_e pk_q;
    logic [13:0] addr_q;
    logic [26:0] remain_q;
    logic t1_prev_q;
    wire in_hdr = word_rdy && (pk_q == PK_HDR);
    wire is_t1 = in_hdr && (h_type == `CPP_TYPE1); // R3
    wire is_t2 = in_hdr && (h_type == `CPP_TYPE2) && t1_prev_q; // R5 R6
    wire t1_wr = is_t1 && (h_op == `CPP_OP_WRITE);
    wire t2_wr = is_t2 && (h_op == `CPP_OP_WRITE);
    wire dword = word_rdy && (pk_q != PK_HDR);
    wire last_word = (remain_q == 27'h1);

    // Register write decode
    wire wr_crc = dword && (addr_q == `CPP_ADDR_CRC);
    wire wr_far = dword && (addr_q == `CPP_ADDR_FAR);
    wire wr_frame_data_input_register = dword && (addr_q == `CPP_ADDR_FRAME_DATA_INPUT_REGISTER);
    wire wr_cmd = dword && (addr_q == `CPP_ADDR_CMD);
    wire wr_cor = dword && (addr_q == `CPP_ADDR_COR);
    wire wr_flr = dword && (addr_q == `CPP_ADDR_FLR);
    wire wr_id = dword && (addr_q == `CPP_ADDR_ID);
    wire [3:0] cmd = w[3:0];
    wire c_write_config_cmd = wr_cmd && (cmd == `CPP_CMD_WRITE_CONFIG_CMD);
    wire c_start = wr_cmd && (cmd == `CPP_CMD_START);
    wire c_checksum_reset_cmd = wr_cmd && (cmd == `CPP_CMD_CHECKSUM_RESET_CMD);
    wire c_switch = wr_cmd && (cmd == `CPP_CMD_SWITCH);
    wire c_desync = wr_cmd && (cmd == `CPP_CMD_DESYNC);

    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            sh_q <= 32'h0;
            cnt_q <= 5'h0;
            aligned_q <= 1'b0;
        end else if (lce) begin
            sh_q <= sh_d;
            cnt_q <= (sync_hit || !aligned_q) ? 5'h0 : cnt_sum[4:0]; // R2
            aligned_q <= c_desync ? 1'b0 : (aligned_q || sync_hit); // R16
        end
    end

    // Packet state
    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            pk_q <= PK_HDR;
            addr_q <= 14'h0;
            remain_q <= 27'h0;
            t1_prev_q <= 1'b0;
        end else if (lce) begin
            if (c_desync) begin
                pk_q <= PK_HDR; // R16
                t1_prev_q <= 1'b0;
            end else if (in_hdr) begin
                t1_prev_q <= t1_wr; // R6 R25
                if (t1_wr) begin
                    addr_q <= h_addr;
                    remain_q <= {16'h0, h_cnt1}; // R4
                    pk_q <= (h_cnt1 != 11'h0) ? PK_T1 : PK_HDR;
                end else if (t2_wr) begin
                    remain_q <= h_cnt2; // R6 R7
                    pk_q <= (h_cnt2 != 27'h0) ? PK_T2 : PK_HDR; // R8
                end
                // Reads and unknown types fall through and only clear t1_prev_q
            end else if (dword) begin
                remain_q <= remain_q - 27'h1;
                t1_prev_q <= 1'b0;
                if (last_word) begin
                    pk_q <= PK_HDR;
                end
            end
        end
    end

    // CRC accumulator and check
    logic [15:0] crc_q;
    logic crc_err_q;
    logic crc_ok_q;
    wire [15:0] crc_upd = crc_step(crc_q, w, addr_q[`CPP_CRC_ADDR_W-1:0]); // R21
    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            crc_q <= 16'h0;
            crc_err_q <= 1'b0;
            crc_ok_q <= 1'b0;
        end else if (lce) begin
            if (c_checksum_reset_cmd) begin
                crc_q <= 16'h0; // R9
            end else if (dword) begin
                crc_q <= crc_upd;
            end
            if (wr_crc) begin
                crc_err_q <= (crc_upd != 16'h0); // R20
                crc_ok_q <= (crc_upd == 16'h0);
            end
        end
    end

    // Options, identity and command state
    logic write_config_cmd_q;
    logic id_ok_q;
    logic id_err_q;
    logic start_q;
    logic [5:0] cor_sel_q;
    cpp_clk_sw_s clk_sw_q;
    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            write_config_cmd_q <= 1'b0;
            id_ok_q <= 1'b0;
            id_err_q <= 1'b0;
            start_q <= 1'b0;
            cor_sel_q <= 6'h0;
            clk_sw_q <= '0;
        end else if (lce) begin
            write_config_cmd_q <= write_config_cmd_q || c_write_config_cmd; // R11
            start_q <= start_q || c_start;
            if (wr_id) begin
                id_ok_q <= (w == `CPP_DEVICE_CODE); // R12
            end
            id_err_q <= id_err_q || (wr_frame_data_input_register && !id_ok_q); // R24
            if (wr_cor) begin
                cor_sel_q <= w[`CPP_COR_CLKSEL_LSB +: `CPP_COR_CLKSEL_W];
            end
            clk_sw_q.sw <= c_switch;
            if (c_switch) begin
                clk_sw_q.sel <= cor_sel_q; // R10
            end
        end else begin
            clk_sw_q.sw <= 1'b0;
        end
    end

    // Frame write path with automatic address advance
    logic [31:0] fa_q;
    logic [15:0] flen_q;
    logic [15:0] widx_q;
    cpp_frame_wr_s fw_q;
    wire frame_ok = wr_frame_data_input_register && write_config_cmd_q && id_ok_q; // R11 R7
    wire frame_end = (widx_q + 16'h1 >= flen_q);
    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            fa_q <= 32'h0;
            flen_q <= 16'h0;
            widx_q <= 16'h0;
            fw_q <= '0;
        end else if (lce) begin
            fw_q.we <= frame_ok;
            if (wr_flr) begin
                flen_q <= w[15:0];
            end
            if (wr_far) begin
                fa_q <= w; // R13
                widx_q <= 16'h0;
            end else if (frame_ok) begin
                fw_q.addr <= fa_q;
                fw_q.data <= w;
                widx_q <= frame_end ? 16'h0 : widx_q + 16'h1;
                if (frame_end) begin
                    fa_q <= fa_q + 32'h1; // R23
                end
            end
        end else begin
            fw_q.we <= 1'b0;
        end
    end

    // Done release and end of configuration
    logic [2:0] done_cnt_q;
    logic done_q;
    logic fin_run_q;
    logic [3:0] fin_cnt_q;
    logic active_q;
    wire done_go = crc_ok_q && start_q && !done_q;
    always_ff @(posedge i_config_clock or posedge lrst) begin
        if (lrst) begin
            done_cnt_q <= 3'h0;
            done_q <= 1'b0;
            fin_run_q <= 1'b0;
            fin_cnt_q <= 4'h0;
            active_q <= 1'b0;
        end else if (len_q[1]) begin
            if (done_go) begin
                done_cnt_q <= done_cnt_q + 3'h1;
                done_q <= (done_cnt_q == `CPP_DONE_DLY); // R17
            end
            if (c_desync && lce) begin
                fin_run_q <= 1'b1;
                fin_cnt_q <= 4'h0;
            end else if (fin_run_q) begin
                fin_cnt_q <= fin_cnt_q + 4'h1;
                if (fin_cnt_q == `CPP_FINISH_CYC - 4'h1) begin
                    fin_run_q <= 1'b0;
                    active_q <= crc_ok_q && done_q; // R14 R15
                end
            end
        end
    end
    // The loader keeps the link clock running through the trailing dummy words R18

    assign o_frame_wr = fw_q;
    assign o_clk_sw = clk_sw_q;
    assign o_done = done_q;
    assign o_user_active = active_q;

    // Status levels into the system clock domain
    localparam int NST = 5;
    wire [NST-1:0] st_l = {id_err_q, done_q, active_q, aligned_q, crc_err_q};
    logic [NST-1:0] st1_q;
    logic [NST-1:0] st2_q;
    logic [31:0] status_q;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st1_q <= '0;
            st2_q <= '0;
        end else begin
            st1_q <= st_l;
            st2_q <= st1_q;
        end
    end
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            status_q <= 32'h0;
        end else if (i_clk_en) begin
            status_q <= 32'h0;
            status_q[`CPP_STAT_CRC_ERR] <= st2_q[0];
            status_q[`CPP_STAT_ALIGNED] <= st2_q[1];
            status_q[`CPP_STAT_ACTIVE] <= st2_q[2];
            status_q[`CPP_STAT_DONE] <= st2_q[3];
            status_q[`CPP_STAT_ID_ERR] <= st2_q[4]; // R24
        end
    end
    assign o_status = status_q;

    // Checks on the link side
    sequence s_desync;
        lce && c_desync;
    endsequence
    sequence s_crc_pass;
        lce && wr_crc && (crc_upd == 16'h0);
    endsequence

    no_data_unsync_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R1
        (lce && !aligned_q) |=> ($stable(crc_q) && !fw_q.we && !clk_sw_q.sw))
        else $error("word taken while unaligned");
    sync_starts_word_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R2
        (lce && sync_hit) |=> (aligned_q && cnt_q == 5'h0))
        else $error("sync did not start a word");
    crc_reset_zero_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R9
        (lce && c_checksum_reset_cmd) |=> (crc_q == 16'h0))
        else $error("checksum not cleared");
    crc_fail_flag_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R20
        (lce && wr_crc && crc_upd != 16'h0) |=> (crc_err_q && !crc_ok_q))
        else $error("bad checksum not flagged");
    desync_drops_align_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R16
        s_desync |=> (!aligned_q && pk_q == PK_HDR))
        else $error("alignment kept after release");
    frame_gate_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R11
        fw_q.we |-> (write_config_cmd_q && id_ok_q))
        else $error("frame write without write-config");
    id_mismatch_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R24
        (lce && wr_frame_data_input_register && !id_ok_q) |=> id_err_q)
        else $error("identity mismatch not flagged");
    active_after_crc_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R14
        $rose(active_q) |-> crc_ok_q)
        else $error("active before final checksum");
    finish_window_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R15
        (s_desync ##1 (len_q[1] && crc_ok_q && done_q && fin_run_q) [*8]) |=> active_q)
        else $error("finish not within window");
    done_release_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R17
        (s_crc_pass ##0 start_q) |-> ##[1:7] done_q)
        else $error("done not released in time");
    frame_advance_a: assert property (@(posedge i_config_clock) disable iff (lrst) // R23
        (lce && frame_ok && frame_end && !wr_far) |=> (fa_q == $past(fa_q) + 32'h1))
        else $error("frame address did not advance");
endmodule

// ===== test/cpp_loader.sv
// Model of the external loader that clocks the configuration stream in
module cpp_loader (
    input wire logic i_link_clk,
    input wire logic i_byte_mode,
    output logic o_valid,
    output logic [7:0] o_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_valid = 1'b0;
        o_data = 8'h00;
    end
    // Word goes out MSB first, one bit or one byte per edge
    task automatic send(input logic [31:0] w);
        logic [7:0] b;
        for (int i = 0; i < (i_byte_mode ? 4 : 32); i++) begin
            @(posedge i_link_clk);
            #1;
            o_valid = 1'b1;
            if (i_byte_mode) begin
                for (int k = 0; k < 8; k++) begin
                    b[k] = w[31 - 8 * i - k];
                end
                o_data = b;
            end else begin
                o_data = {~o_data[7:1], w[31 - i]};
            end
        end
    endtask
    // Released pins show the inverse of the last value
    task automatic idle();
        @(posedge i_link_clk);
        #1;
        o_valid = 1'b0;
        o_data = ~o_data;
    endtask
endmodule

// ===== test/config_packet_processor_crc_test.sv
// Self-checking bench of the configuration packet processor
`include "cpp_defines.svh"
module config_packet_processor_crc_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cpp_pkg::*;
    logic i_clock = 1'b0;
    logic i_config_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_byte_mode = 1'b0;
    logic i_cfg_valid;
    logic [7:0] i_cfg_data;
    cpp_frame_wr_s o_frame_wr;
    cpp_clk_sw_s o_clk_sw;
    logic o_done;
    logic o_user_active;
    logic [31:0] o_status;
    int num_errors = 0;
    int samples_checked = 0;
    int n_sw = 0;
    int cycles = 0;
    logic [15:0] crc = 16'h0000;
    logic [63:0] exp_q[$];

    initial begin
        forever #4 i_clock = ~i_clock;
    end
    // Link clock free-running, phase unrelated to the system clock
    initial begin
        #1.3;
        forever #3 i_config_clock = ~i_config_clock;
    end

    cpp_core DUT (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_byte_mode(i_byte_mode),
        .i_config_clock(i_config_clock), .i_cfg_valid(i_cfg_valid), .i_cfg_data(i_cfg_data),
        .o_frame_wr(o_frame_wr), .o_clk_sw(o_clk_sw), .o_done(o_done), .o_user_active(o_user_active),
        .o_status(o_status));
    cpp_loader LOADER (.i_link_clk(i_config_clock), .i_byte_mode(i_byte_mode), .o_valid(i_cfg_valid),
        .o_data(i_cfg_data));

    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            complete_run();
        end
    end

    // Pulses are sampled mid-cycle, away from the launching edge
    always @(negedge i_config_clock) begin
        if (o_clk_sw.sw === 1'b1)
            n_sw++;
        if (o_frame_wr.we === 1'b1) begin
            if (exp_q.size() == 0)
                chk({o_frame_wr.addr, o_frame_wr.data}, 64'h0);
            else
                chk({o_frame_wr.addr, o_frame_wr.data}, exp_q.pop_front());
        end
    end

    function automatic logic [15:0] step(input logic [15:0] c, input logic d);
        logic in;
        in = d ^ c[15];
        return {in ^ c[14], c[13:2], in ^ c[1], c[0], in};
    endfunction

    task automatic cov(input logic [4:0] a, input logic [31:0] d);
        for (int i = 0; i < 37; i++) begin
            crc = step(crc, i < 5 ? a[i] : d[i - 5]);
        end
    endtask

    function automatic logic [31:0] h1(input logic [13:0] a, input logic [10:0] n);
        return {`CPP_TYPE1, `CPP_OP_WRITE, a, 2'h0, n};
    endfunction

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        LOADER.send(h1(a, 11'h001));
        LOADER.send(d);
        cov(a[4:0], d);
    endtask

    task automatic fd(input logic [31:0] fa, input logic [31:0] d);
        LOADER.send(d);
        cov(5'(`CPP_ADDR_FRAME_DATA_INPUT_REGISTER), d);
        exp_q.push_back({fa, d});
    endtask

    task automatic wait_out(input bit act, input int lim, input logic exp);
        int n;
        n = 0;
        while (n < lim && (act ? o_user_active : o_done) !== 1'b1) begin
            @(negedge i_config_clock);
            n++;
        end
        chk(act ? o_user_active : o_done, exp);
    endtask

    task automatic run(input logic bm, input logic bad);
        logic [31:0] x;
        logic [15:0] c;
        logic b;
        @(posedge i_clock);
        #1;
        i_rst = 1'b1;
        i_byte_mode = bm;
        repeat (12) @(posedge i_clock);
        #1;
        chk({o_done, o_user_active, o_status}, 64'h0);
        i_rst = 1'b0;
        n_sw = 0;
        repeat (6) @(posedge i_config_clock);
        wr(`CPP_ADDR_COR, 32'h0000_0015);
        wr(`CPP_ADDR_CMD, `CPP_CMD_SWITCH);
        LOADER.send(`CPP_SYNC_WORD);
        wr(`CPP_ADDR_FRAME_DATA_INPUT_REGISTER, 32'h1111_0000);
        wr(`CPP_ADDR_CMD, `CPP_CMD_CHECKSUM_RESET_CMD);
        crc = 16'h0000;
        LOADER.idle();
        repeat (6) @(posedge i_clock);
        #1;
        chk({o_status[13], o_status[1]}, 2'b11);
        // A switch command sent while the enable is low must be lost
        i_clk_en = 1'b0;
        repeat (4) @(posedge i_config_clock);
        LOADER.send(h1(`CPP_ADDR_CMD, 11'h001));
        LOADER.send({28'h0, `CPP_CMD_SWITCH});
        LOADER.idle();
        @(posedge i_clock);
        #1;
        chk(o_status[1], 1'b1);
        i_clk_en = 1'b1;
        repeat (4) @(posedge i_config_clock);
        // A read header's word count brings no data words with it
        LOADER.send({`CPP_TYPE1, `CPP_OP_READ, `CPP_ADDR_CMD, 2'h0, 11'h001});
        LOADER.send({28'h0, `CPP_CMD_SWITCH});
        LOADER.send(32'he000_0000);
        wr(`CPP_ADDR_COR, 32'h0000_002a);
        wr(`CPP_ADDR_CMD, `CPP_CMD_SWITCH);
        wr(`CPP_ADDR_FLR, 32'h0000_0002);
        wr(`CPP_ADDR_ID, `CPP_DEVICE_CODE);
        wr(`CPP_ADDR_FAR, 32'h0000_0000);
        wr(`CPP_ADDR_CMD, `CPP_CMD_WRITE_CONFIG_CMD);
        LOADER.send(h1(`CPP_ADDR_FRAME_DATA_INPUT_REGISTER, 11'h000));
        LOADER.send({`CPP_TYPE2, `CPP_OP_WRITE, 27'h000_0004});
        for (int i = 0; i < 4; i++) begin
            fd(i / 2, 32'hc0de_0000 + i);
        end
        wr(`CPP_ADDR_FAR, 32'h0000_0005);
        LOADER.send(h1(`CPP_ADDR_FRAME_DATA_INPUT_REGISTER, 11'h002));
        fd(32'h5, 32'hbeef_0001);
        fd(32'h5, 32'hbeef_0002);
        wr(`CPP_ADDR_CMD, `CPP_CMD_START);
        // Trailing sixteen bits steer the accumulator to zero
        c = crc;
        for (int i = 0; i < 37; i++) begin
            b = (i < 21) ? 1'b0 : c[15];
            if (i >= 5)
                x[i - 5] = b;
            c = step(c, b);
        end
        LOADER.send(h1(`CPP_ADDR_CRC, 11'h001));
        LOADER.send(x ^ {31'h0, bad});
        LOADER.idle();
        wait_out(1'b0, 7, ~bad);
        chk(o_user_active, 1'b0);
        wr(`CPP_ADDR_CMD, `CPP_CMD_DESYNC);
        LOADER.idle();
        wait_out(1'b1, 16, ~bad);
        repeat (4) LOADER.send(32'hffff_ffff);
        wr(`CPP_ADDR_CMD, `CPP_CMD_SWITCH);
        LOADER.idle();
        repeat (12) @(posedge i_clock);
        #1;
        chk(o_status, bad ? 32'h0000_2001 : 32'h0000_3004);
        chk(n_sw, 1);
        chk(o_clk_sw.sel, 6'h2a);
        chk(exp_q.size(), 0);
    endtask

    initial begin
        run(1'b0, 1'b0);
        run(1'b1, 1'b1);
        complete_run();
    end
endmodule
